// file: design/adc_pkg.sv
// Shared constants, field layouts and types of the two-unit converter.
// Assumes one system clock at 20 MHz and an external conversion-clock
// enable produced by the chip's clock generation logic.
package adc_pkg;

  localparam int UNITS = 2;
  localparam int CH_UNIT0 = 8;
  localparam int CH_UNIT1 = 21;
  localparam int RES_BITS = 12;
  localparam int DATA_W = 16;
  localparam int SLOTS = 32;

  // Conversion times as stated, at the nominal conversion clock rate.
  localparam int CONV_CLK_MHZ = 60;
  localparam int T12_NS = 480;
  localparam int T10_NS = 450;
  localparam int T8_NS = 420;
  localparam logic [4:0] T12_TICKS =
    5'((T12_NS * CONV_CLK_MHZ + 999) / 1000);
  localparam logic [4:0] T10_TICKS =
    5'((T10_NS * CONV_CLK_MHZ + 999) / 1000);
  localparam logic [4:0] T8_TICKS =
    5'((T8_NS * CONV_CLK_MHZ + 999) / 1000);

  // Register map, byte addresses on the 12-bit APB address.
  localparam logic [11:0] UNIT_STRIDE = 12'h100;
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] RES_BASE = 8'h80;
  localparam logic [11:0] RATIO_ADDR = 12'h200;

  // Control register fields.
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ACC_LSB = 1;
  localparam int CTRL_ADD_LSB = 3;
  localparam int CTRL_TGT_LSB = 5;
  localparam int CTRL_CH_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] RATIO_RST = 2'h0;

  // Result slots inside one unit; 0 to 20 are channel registers on unit one, 0 to 7 on unit zero.
  localparam logic [4:0] SLOT_DUP = 5'h18;
  localparam logic [4:0] SLOT_EXT0 = 5'h19;
  localparam logic [4:0] SLOT_EXT1 = 5'h1a;
  localparam logic [4:0] SLOT_DIAG = 5'h1b;
  localparam logic [4:0] SLOT_TEMP = 5'h1c;
  localparam logic [4:0] SLOT_VREF = 5'h1d;

  // Source codes presented to the analog multiplexer.
  localparam logic [4:0] SRC_TEMP = 5'h1d;
  localparam logic [4:0] SRC_VREF = 5'h1e;
  localparam logic [4:0] SRC_DIAG = 5'h1f;

  localparam logic [4:0] ADD4_LEFT = 5'h03;
  localparam logic [4:0] ADD16_LEFT = 5'h0f;

  typedef enum logic [1:0] {
    ACC_12 = 2'h0,
    ACC_10 = 2'h1,
    ACC_8 = 2'h2
  } acc_t;

  typedef enum logic [1:0] {
    ADD_OFF = 2'h0,
    ADD_X4 = 2'h1,
    ADD_X16 = 2'h2
  } add_t;

  typedef enum logic [2:0] {
    TGT_CH = 3'h0,
    TGT_DBL = 3'h1,
    TGT_EXT0 = 3'h2,
    TGT_EXT1 = 3'h3,
    TGT_TEMP = 3'h4,
    TGT_VREF = 3'h5,
    TGT_DIAG = 3'h6
  } tgt_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [4:0] src;
    logic [11:0] trial;
    logic busy;
  } ana_sel_t;

endpackage

// file: design/sar_adc_result_control.sv
// Control and result storage of the two-unit 12-bit converter, APB slave.
// Assumes synchronous APB at mclk and a one-cycle conversion-clock enable
// from the clock generation logic.
//
// What this block does
// - Twelve-bit conversions, 0.48/0.45/0.42 us per channel.
// - Bus to conversion clock ratio 1,2,4,8 only.
// - Conversion clock comes from outside, only consumed.
// - 29 channel registers: unit0 8, unit1 21.
// - One duplication register per unit.
// - Two extended duplication registers per unit.
// - Unit one holds a temperature sensor register.
// - Unit one holds an internal reference register.
// - One self-diagnosis register per unit.
// - Results land in 16-bit data registers.
// - Accuracy 8/10/12 sets width and time.
// - Addition mode widens result by 2 or 4.
// - Double trigger: first to channel, second duplicated.
`timescale 1ns/1ps
module sar_adc_result_control (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire adc_pkg::apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_clk_en,
  input wire logic [1:0] cmp_hi,
  output adc_pkg::ana_sel_t [1:0] ana_sel,
  output logic [1:0] ratio_sel
);

  typedef enum logic [2:0] {
    U_IDLE = 3'b001,
    U_RUN = 3'b010,
    U_STORE = 3'b100
  } unit_state_t;

  logic setup_ph;
  logic access_wr;
  logic [1:0] unit_hit;
  logic [1:0][31:0] unit_rdata;
  logic [1:0] ratio_r;
  logic [31:0] prdata_r;
  logic ratio_hit;

  assign setup_ph = apb_req.psel & ~apb_req.penable;
  assign access_wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign ratio_hit = (apb_req.paddr == adc_pkg::RATIO_ADDR);
  assign pready = 1'b1;
  assign pslverr = apb_req.psel & apb_req.penable & ~ratio_hit
                   & ~(|unit_hit);
  assign prdata = prdata_r;
  assign ratio_sel = ratio_r;

  // The ratio is only requested here; the clock generation logic makes the
  // enable, so a 2-bit field cannot encode anything but the four ratios.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ratio_r <= adc_pkg::RATIO_RST;
    end else if (access_wr && ratio_hit) begin
      ratio_r <= apb_req.pwdata[1:0];
    end
  end

  // Read data is captured in the setup cycle, so the word handed out is
  // one whole register value even if a store lands in the access cycle.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph && !apb_req.pwrite) begin
      if (ratio_hit) begin
        prdata_r <= {30'h0000_0000, ratio_r};
      end else if (unit_hit[0]) begin
        prdata_r <= unit_rdata[0];
      end else if (unit_hit[1]) begin
        prdata_r <= unit_rdata[1];
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  for (genvar u = 0; u < adc_pkg::UNITS; u++) begin : g_unit
    localparam logic [4:0] NCH = (u == 0) ? 5'(adc_pkg::CH_UNIT0)
                                          : 5'(adc_pkg::CH_UNIT1);
    localparam logic [11:0] BASE = 12'(u * adc_pkg::UNIT_STRIDE);

    unit_state_t state_r;
    adc_pkg::acc_t acc_r;
    adc_pkg::add_t add_r;
    adc_pkg::tgt_t tgt_r;
    logic [4:0] ch_r;
    logic dbl_second_r;
    logic [4:0] add_left_r;
    logic [15:0] sum_r;
    logic [15:0] mem_r [adc_pkg::SLOTS];
    logic in_unit;
    logic [7:0] off;
    logic [4:0] rd_slot;
    logic slot_ok;
    logic ctrl_wr;
    logic start_ok;
    logic tgt_ok;
    logic eng_start;
    logic eng_busy;
    logic eng_done;
    logic [11:0] eng_result;
    logic [11:0] eng_trial;
    logic [3:0] bits;
    logic [4:0] ticks;
    logic [4:0] wr_slot;
    logic [4:0] src;
    logic [15:0] sum_nxt;
    adc_pkg::tgt_t wr_tgt;

    assign in_unit = (apb_req.paddr[11:8] == BASE[11:8]);
    assign off = apb_req.paddr[7:0];
    assign rd_slot = off[6:2];
    assign ctrl_wr = access_wr && in_unit && (off == adc_pkg::CTRL_OFF);
    assign wr_tgt =
      adc_pkg::tgt_t'(apb_req.pwdata[adc_pkg::CTRL_TGT_LSB +: 3]);

    // Only existing result slots decode; the rest answer with an error.
    always_comb begin
      slot_ok = 1'b0;
      if (rd_slot < NCH) begin
        slot_ok = 1'b1;
      end else if (rd_slot == adc_pkg::SLOT_DUP
                   || rd_slot == adc_pkg::SLOT_EXT0
                   || rd_slot == adc_pkg::SLOT_EXT1
                   || rd_slot == adc_pkg::SLOT_DIAG) begin
        slot_ok = 1'b1;
      end else if (u == 1 && (rd_slot == adc_pkg::SLOT_TEMP
                   || rd_slot == adc_pkg::SLOT_VREF)) begin
        slot_ok = 1'b1;
      end
    end

    always_comb begin
      unit_hit[u] = 1'b0;
      unit_rdata[u] = 32'h0000_0000;
      if (in_unit && off == adc_pkg::CTRL_OFF) begin
        unit_hit[u] = 1'b1;
        unit_rdata[u] = {19'h0_0000, ch_r, tgt_r, add_r, acc_r, 1'b0};
      end else if (in_unit && off == adc_pkg::STAT_OFF) begin
        unit_hit[u] = 1'b1;
        unit_rdata[u] = {30'h0000_0000, dbl_second_r, state_r != U_IDLE};
      end else if (in_unit && off[7] && off[1:0] == 2'h0 && slot_ok) begin
        unit_hit[u] = 1'b1;
        unit_rdata[u] = {16'h0000, mem_r[rd_slot]};
      end
    end

    // Temperature and reference sources exist on unit one only.
    assign tgt_ok = (wr_tgt == adc_pkg::TGT_TEMP
                     || wr_tgt == adc_pkg::TGT_VREF) ? (u == 1)
                    : (wr_tgt <= adc_pkg::TGT_DIAG);
    assign start_ok = ctrl_wr && (state_r == U_IDLE)
                      && apb_req.pwdata[adc_pkg::CTRL_START_BIT] && tgt_ok
                      && (apb_req.pwdata[adc_pkg::CTRL_CH_LSB +: 5] < NCH);

    always_comb begin
      case (acc_r)
        adc_pkg::ACC_10: begin
          bits = 4'd10;
          ticks = adc_pkg::T10_TICKS;
        end
        adc_pkg::ACC_8: begin
          bits = 4'd8;
          ticks = adc_pkg::T8_TICKS;
        end
        default: begin
          bits = 4'd12;
          ticks = adc_pkg::T12_TICKS;
        end
      endcase
    end

    always_comb begin
      case (tgt_r)
        adc_pkg::TGT_DBL: wr_slot = dbl_second_r ? adc_pkg::SLOT_DUP
                                                 : ch_r;
        adc_pkg::TGT_EXT0: wr_slot = adc_pkg::SLOT_EXT0;
        adc_pkg::TGT_EXT1: wr_slot = adc_pkg::SLOT_EXT1;
        adc_pkg::TGT_TEMP: wr_slot = adc_pkg::SLOT_TEMP;
        adc_pkg::TGT_VREF: wr_slot = adc_pkg::SLOT_VREF;
        adc_pkg::TGT_DIAG: wr_slot = adc_pkg::SLOT_DIAG;
        default: wr_slot = ch_r;
      endcase
    end

    always_comb begin
      case (tgt_r)
        adc_pkg::TGT_TEMP: src = adc_pkg::SRC_TEMP;
        adc_pkg::TGT_VREF: src = adc_pkg::SRC_VREF;
        adc_pkg::TGT_DIAG: src = adc_pkg::SRC_DIAG;
        default: src = ch_r;
      endcase
    end

    assign eng_start = start_ok || (state_r == U_RUN && eng_done
                                    && add_left_r != 5'h00);
    assign sum_nxt = sum_r + {4'h0, eng_result};

    // Conversions advance only on the externally made enable.
    sar_engine u_eng (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tick(conv_clk_en),
      .start(eng_start),
      .bits(bits),
      .ticks(ticks),
      .cmp_hi(cmp_hi[u]),
      .busy(eng_busy),
      .done(eng_done),
      .result(eng_result),
      .trial(eng_trial)
    );

    assign ana_sel[u].src = src;
    assign ana_sel[u].trial = eng_trial;
    assign ana_sel[u].busy = eng_busy;

    // Configuration is frozen while a conversion is running.
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        acc_r <= adc_pkg::acc_t'(
                 adc_pkg::CTRL_RST[adc_pkg::CTRL_ACC_LSB +: 2]);
        add_r <= adc_pkg::add_t'(
                 adc_pkg::CTRL_RST[adc_pkg::CTRL_ADD_LSB +: 2]);
        tgt_r <= adc_pkg::tgt_t'(
                 adc_pkg::CTRL_RST[adc_pkg::CTRL_TGT_LSB +: 3]);
        ch_r <= adc_pkg::CTRL_RST[adc_pkg::CTRL_CH_LSB +: 5];
      end else if (ctrl_wr && state_r == U_IDLE) begin
        acc_r <= adc_pkg::acc_t'(apb_req.pwdata[adc_pkg::CTRL_ACC_LSB +: 2]);
        add_r <= adc_pkg::add_t'(apb_req.pwdata[adc_pkg::CTRL_ADD_LSB +: 2]);
        tgt_r <= wr_tgt;
        ch_r <= apb_req.pwdata[adc_pkg::CTRL_CH_LSB +: 5];
      end
    end

    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        state_r <= U_IDLE;
        add_left_r <= 5'h00;
        sum_r <= 16'h0000;
      end else begin
        case (state_r)
          U_IDLE: begin
            if (start_ok) begin
              state_r <= U_RUN;
              sum_r <= 16'h0000;
              case (adc_pkg::add_t'(
                    apb_req.pwdata[adc_pkg::CTRL_ADD_LSB +: 2]))
                adc_pkg::ADD_X4: add_left_r <= adc_pkg::ADD4_LEFT;
                adc_pkg::ADD_X16: add_left_r <= adc_pkg::ADD16_LEFT;
                default: add_left_r <= 5'h00;
              endcase
            end
          end
          U_RUN: begin
            if (eng_done) begin
              // Four or sixteen results add two or four bits.
              sum_r <= sum_nxt;
              if (add_left_r == 5'h00) begin
                state_r <= U_STORE;
              end else begin
                add_left_r <= add_left_r - 5'h01;
              end
            end
          end
          U_STORE: state_r <= U_IDLE;
          default: state_r <= U_IDLE;
        endcase
      end
    end

    // The whole sum lands in one edge, never piecewise.
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        for (int i = 0; i < adc_pkg::SLOTS; i++) begin
          mem_r[i] <= 16'h0000;
        end
      end else if (state_r == U_STORE) begin
        mem_r[wr_slot] <= sum_r;
      end
    end

    // Double trigger pairing restarts on any control write while idle, except one that starts a double-trigger conversion.
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        dbl_second_r <= 1'b0;
      end else if (state_r == U_STORE && tgt_r == adc_pkg::TGT_DBL) begin
        dbl_second_r <= ~dbl_second_r;
      end else if (ctrl_wr && state_r == U_IDLE && !start_ok) begin
        dbl_second_r <= 1'b0;
      end else if (start_ok && wr_tgt != adc_pkg::TGT_DBL) begin
        dbl_second_r <= 1'b0;
      end
    end
  end

endmodule

// file: design/sar_engine.sv
// One successive-approximation sequencer, paced by conversion-clock ticks.
// Assumes the comparator answer for the presented trial code is valid at
// the next tick.
`timescale 1ns/1ps
module sar_engine (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic start,
  input wire logic [3:0] bits,
  input wire logic [4:0] ticks,
  input wire logic cmp_hi,
  output logic busy,
  output logic done,
  output logic [11:0] result,
  output logic [11:0] trial
);

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b01,
    ENG_RUN = 2'b10
  } eng_state_t;

  eng_state_t state_r;
  logic [4:0] cnt_r;
  logic [11:0] code_r;
  logic [11:0] mask_r;
  logic [11:0] trial_r;
  logic [11:0] result_r;
  logic done_r;
  logic [11:0] code_nxt;

  assign code_nxt = cmp_hi ? trial_r : code_r;
  assign busy = (state_r == ENG_RUN);
  assign done = done_r;
  assign result = result_r;
  assign trial = trial_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= ENG_IDLE;
      cnt_r <= 5'h00;
      code_r <= 12'h000;
      mask_r <= 12'h000;
      trial_r <= 12'h000;
      result_r <= 12'h000;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        ENG_IDLE: begin
          if (start) begin
            state_r <= ENG_RUN;
            cnt_r <= 5'h00;
            code_r <= 12'h000;
            mask_r <= 12'h800;
            trial_r <= 12'h800;
          end
        end
        ENG_RUN: begin
          if (tick) begin
            cnt_r <= cnt_r + 5'h01;
            // Only the top bits are trialled at reduced accuracy.
            if (cnt_r < {1'b0, bits}) begin
              code_r <= code_nxt;
              mask_r <= mask_r >> 1;
              trial_r <= code_nxt | (mask_r >> 1);
            end
            if (cnt_r == ticks - 5'h01) begin
              state_r <= ENG_IDLE;
              done_r <= 1'b1;
              result_r <= code_r >> (4'd12 - bits);
            end
          end
        end
        default: state_r <= ENG_IDLE;
      endcase
    end
  end

endmodule

// file: test/ana_model.sv
// Far-side model: per-unit comparators and the conversion-clock enable.
// Assumes the bench sets one base level per unit.
`timescale 1ns/1ps
module ana_model (
  input wire logic mclk,
  input wire logic [1:0] ratio_sel,
  input wire adc_pkg::ana_sel_t [1:0] ana_sel,
  input wire logic [1:0][11:0] lvl,
  output logic [1:0] cmp_hi,
  output logic conv_clk_en
);
  logic [2:0] cnt = 3'h0;
  // Each source shows its own level, so a wrong source code misreads.
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      cmp_hi[u] = (lvl[u] ^ {7'h00, ana_sel[u].src}) >= ana_sel[u].trial;
    end
  end
  // The enable is made outside the converter, at the requested ratio.
  initial conv_clk_en = 1'b0;
  always @(posedge mclk) begin
    cnt <= cnt + 3'h1;
    conv_clk_en <= (cnt & ((3'h1 << ratio_sel) - 3'h1)) == 3'h0;
  end
endmodule

// file: test/sar_adc_result_control_properties.sv
// Port checker of the converter control block.
// Assumes it is bound into the top module by the statement below.
`timescale 1ns/1ps
module sar_adc_checker (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire adc_pkg::apb_req_t apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_clk_en,
  input wire logic [1:0] cmp_hi,
  input wire adc_pkg::ana_sel_t [1:0] ana_sel,
  input wire logic [1:0] ratio_sel
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic acc;
  assign acc = apb_req.psel && apb_req.penable;
  chk_start_busy: assert property (
    acc && apb_req.pwrite && apb_req.paddr == 12'h000 &&
    apb_req.pwdata[0] && apb_req.pwdata[7:5] == 3'h0 &&
    apb_req.pwdata[12:8] < 5'h08 && !ana_sel[0].busy
    |-> ##[1:3] ana_sel[0].busy) else $error("start did not run");
  chk_trial_mid: assert property (
    $rose(ana_sel[1].busy) |-> ana_sel[1].trial == 12'h800)
    else $error("first trial code wrong");
  chk_busy_hold: assert property (
    $rose(ana_sel[0].busy) |-> ana_sel[0].busy [*8])
    else $error("conversion ended too soon");
  // No setting could exceed this window: busy falls between added conversions and one lasts 29 ticks at most.
  chk_busy_end: assert property (
    $rose(ana_sel[1].busy) && ratio_sel < 2'h2
    |-> ##[20:1000] !ana_sel[1].busy) else $error("conversion hung");
  chk_ratio_write: assert property (
    acc && apb_req.pwrite && apb_req.paddr == 12'h200
    |=> ratio_sel == $past(apb_req.pwdata[1:0]))
    else $error("ratio not taken");
  chk_slot_unmapped: assert property (
    acc && apb_req.paddr inside {12'h0a0, 12'h0f0, 12'h0f4} |-> pslverr)
    else $error("missing register answered");
  chk_unit_one: assert property (
    acc && apb_req.paddr == 12'h1f4 |-> !pslverr)
    else $error("reference register missing");
  chk_res_width: assert property (
    acc && !apb_req.pwrite && apb_req.paddr[7] && !pslverr
    |-> prdata[31:16] == 16'h0000) else $error("result too wide");
  chk_tick_hold: assert property (
    ana_sel[1].busy && $past(ana_sel[1].busy) && !$past(conv_clk_en) &&
    !$past(conv_clk_en, 2)
    |-> $stable(ana_sel[1].trial) || ana_sel[1].trial == 12'h800)
    else $error("trial moved without a tick");
  cov_unit0: cover property ($rose(ana_sel[0].busy));
  cov_unit1: cover property ($rose(ana_sel[1].busy));
  cov_err: cover property (acc && pslverr);
endmodule

bind sar_adc_result_control sar_adc_checker sar_adc_checker_i (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .apb_req(apb_req),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .conv_clk_en(conv_clk_en),
  .cmp_hi(cmp_hi),
  .ana_sel(ana_sel),
  .ratio_sel(ratio_sel)
);

// file: test/testbench.sv
// Self-checking bench of the converter control block over APB.
// Assumes the analog model supplies comparators and the clock enable.
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  adc_pkg::apb_req_t req = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic conv_clk_en;
  logic [1:0] cmp_hi;
  logic [1:0] ratio_sel;
  adc_pkg::ana_sel_t [1:0] ana_sel;
  logic [1:0][11:0] lvl = {12'h3c7, 12'h9a5};
  logic [15:0] mem [2][32];
  logic [31:0] q;
  logic e;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  int ticks = 0;

  always #25 mclk = ~mclk;

  sar_adc_result_control sar_adc_result_control_i (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .apb_req(req),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .conv_clk_en(conv_clk_en),
    .cmp_hi(cmp_hi),
    .ana_sel(ana_sel),
    .ratio_sel(ratio_sel)
  );
  ana_model ana_model_i (
    .mclk(mclk),
    .ratio_sel(ratio_sel),
    .ana_sel(ana_sel),
    .lvl(lvl),
    .cmp_hi(cmp_hi),
    .conv_clk_en(conv_clk_en)
  );

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if ((ana_sel[0].busy | ana_sel[1].busy) === 1'b1 && conv_clk_en)
      ticks <= ticks + 1;
    if (cyc == 40000) begin
      fails = fails + 1;
      end_of_test;
    end
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    req <= '0;
  endtask

  function automatic logic [31:0] ctl(input int acc, add, tgt, ch);
    return 32'(ch << 8 | tgt << 5 | add << 3 | acc << 1 | 1);
  endfunction
  function automatic logic [11:0] ra(input int u, input logic [4:0] s);
    return 12'(u * 256 + 128 + 4 * s);
  endfunction
  function automatic logic [15:0] lv(input int u, input logic [4:0] s);
    return {4'h0, lvl[u] ^ {7'h00, s}};
  endfunction

  // The old value is read mid-run, so a half-written result shows up.
  task automatic run(input int u, input logic [31:0] c,
      input logic [4:0] s, input logic [15:0] x, input int n);
    int t0;
    apb(1'b1, 12'(u * 256), c);
    t0 = ticks;
    apb(1'b0, ra(u, s), 32'h0);
    check(q, {16'h0, mem[u][s]});
    q = 32'h1;
    while (q[0] !== 1'b0) apb(1'b0, 12'(u * 256 + 4), 32'h0);
    apb(1'b0, ra(u, s), 32'h0);
    check(q, {16'h0, x});
    mem[u][s] = x;
    if (n > 0)
      check(32'(ticks - t0 >= n - 1 && ticks - t0 <= n + 1), 1);
  endtask

  task automatic t_ratio;
    apb(1'b0, 12'h200, 32'h0);
    check(q, 32'h0);
    for (int r = 3; r >= 0; r--) begin
      apb(1'b1, 12'h200, r);
      apb(1'b0, 12'h200, 32'h0);
      check(q, r);
      check(ratio_sel, r);
    end
    apb(1'b1, 12'h200, 32'h1);
  endtask

  task automatic t_acc;
    int n [3] = '{29, 27, 26};
    for (int a = 0; a < 3; a++)
      run(1, ctl(a, 0, 0, 20), 5'h14, lv(1, 20) >> 2 * a, n[a]);
  endtask

  task automatic t_add;
    logic [15:0] v;
    v = lv(0, 5'h07);
    run(0, ctl(1, 1, 0, 7), 5'h07, (v >> 2) << 2, 0);
    run(0, ctl(0, 2, 0, 7), 5'h07, v << 4, 0);
  endtask

  task automatic t_tgt;
    logic [4:0] sl [5] = '{5'h19, 5'h1a, 5'h1c, 5'h1d, 5'h1b};
    logic [4:0] sr [5] = '{5'h05, 5'h05, 5'h1d, 5'h1e, 5'h1f};
    logic [31:0] c;
    for (int i = 0; i < 5; i++) begin
      c = ctl(0, 0, i + 2, 5);
      run(1, c, sl[i], lv(1, sr[i]), 29);
    end
  endtask

  task automatic t_dbl;
    run(0, ctl(0, 0, 1, 3), 5'h03, lv(0, 5'h03), 29);
    lvl[0] <= 12'h5e1;
    @(posedge mclk);
    run(0, ctl(0, 0, 1, 3), 5'h18, lv(0, 5'h03), 29);
    apb(1'b0, ra(0, 5'h03), 32'h0);
    check(q, {16'h0, mem[0][3]});
  endtask

  task automatic t_ref;
    apb(1'b1, 12'h000, ctl(0, 0, 4, 0));
    apb(1'b0, 12'h004, 32'h0);
    check(q, 32'h0);
    apb(1'b0, ra(0, 5'h1c), 32'h0);
    check(e, 32'h1);
    apb(1'b0, ra(0, 5'h1d), 32'h0);
    check(e, 32'h1);
    apb(1'b0, ra(0, 5'h08), 32'h0);
    check(e, 32'h1);
    apb(1'b0, ra(1, 5'h14), 32'h0);
    check(e, 32'h0);
    // A channel beyond the unit's count must not start a conversion.
    apb(1'b1, 12'h100, ctl(0, 0, 0, 21));
    apb(1'b0, 12'h104, 32'h0);
    check(q, 32'h0);
  endtask

  initial begin
    foreach (mem[i, j]) mem[i][j] = 16'h0000;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    t_ratio;
    t_acc;
    t_add;
    t_tgt;
    t_dbl;
    t_ref;
    end_of_test;
  end
endmodule
